// ===== hw/irq_pkg.sv
// Shared constants and types of the vectored interrupt controller
package irq_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on the plain register port)
	// ------------------------------------------------------------
	localparam logic [2:0] ADDR_CTRL0 = 3'h0;
	localparam logic [2:0] ADDR_CTRL1 = 3'h1;
	localparam logic [2:0] ADDR_CTRL2 = 3'h2;
	localparam logic [2:0] ADDR_CTRL3 = 3'h3;
	localparam logic [2:0] ADDR_EDGE = 3'h4;
	localparam logic [2:0] ADDR_STATUS = 3'h5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int GIE_BIT = 0;
	localparam int FLAG_LO = 4;
	localparam int EN_LO = 0;
	localparam int GRP_W = 4;
	localparam logic [7:0] CTRL3_MASK = 8'h11;
	localparam logic [7:0] CTRL0_MASK = 8'h7F;
	localparam logic [7:0] EDGE_MASK = 8'h0F;
	localparam logic [7:0] RESET_VAL = 8'h00;

	// ------------------------------------------------------------
	// Sources, index = priority (0 highest)
	// ------------------------------------------------------------
	localparam int NSRC = 14;
	localparam int SRC_EXT0 = 0;
	localparam int SRC_EXT1 = 1;
	localparam int SRC_SERIAL = 2;
	localparam int SRC_LOWV = 3;
	localparam int SRC_CONV = 4;
	localparam int SRC_EEPROM = 5;
	localparam int SRC_TB0 = 6;
	localparam int SRC_PERP = 7;
	localparam int SRC_PERA = 8;
	localparam int SRC_STDP = 9;
	localparam int SRC_STDA = 10;
	localparam int SRC_TB1 = 11;
	localparam int SRC_RSV0 = 12;
	localparam int SRC_RSV1 = 13;

	// Vector spacing and base (program word addresses)
	localparam logic [11:0] VEC_BASE = 12'h004;
	localparam logic [11:0] VEC_STEP = 12'h004;

	// Edge select encodings
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Serial module event groups
	typedef struct packed {
		logic byte_done;
		logic addr_match;
		logic bus_timeout;
	} sync_events_s;

	typedef struct packed {
		logic tx_empty;
		logic tx_idle;
		logic rx_avail;
		logic rx_overrun;
		logic addr_detect;
		logic pin_wake;
	} uart_events_s;

	// Core handshake
	typedef struct packed {
		logic [11:0] next_pc;
		logic stack_full;
		logic ret_irq;
		logic fetch_ok;
	} core_status_s;

	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_PUSH = 2'b01,
		ST_LOAD = 2'b11
	} take_e;

endpackage

// ===== hw/mcu_interrupt_controller.sv
// Prioritised vectored interrupt controller with register port
//
// Behaviour
// - Group1 register: four flags bits 7..4, enables bits 3..0, reset zero.
// - Group2 register: four timer match flags bits 7..4, enables 3..0.
// - Group3 register: time base one flag bit 4, enable bit 0, rest zero.
// - Source event sets its flag regardless of enable, except an external pin, which needs its enable.
// - Flag with enable low causes no vector jump but stays set.
// - Global enable low blocks every interrupt.
// - Taking interrupt pushes next address then loads the vector into PC.
// - Return from interrupt pops the saved program counter.
// - Each source owns a distinct vector address.
// - Taking an interrupt clears the global enable in hardware.
// - Requests while global enable is low still set and hold flags.
// - Software setting global enable in a handler allows nesting.
// - Full stack blocks acknowledgement until the pointer drops.
// - Simultaneous enabled requests are served in fixed priority.
// - Flag rising wakes from sleep; already set flag does not.
// - External flag set on the edge chosen by its edge select.
// - External pin works only when enabled, pin-shared and input.
// - Servicing an external interrupt clears its flag and global enable.
// - Sync serial modes set serial flag on byte, address match, time-out.
// - UART mode sets serial flag on any of six UART conditions.
// - Servicing serial interrupt clears only its own flag.
// - Edge select: 00 off, 01 rise, 10 fall, 11 both.
// - Global enable is bit 0 of control register zero, reset zero.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps

module mcu_interrupt_controller
	import irq_pkg::*;
#(
	parameter int PC_W = 12
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic ext_pin_zero,
	input wire logic ext_pin_one,
	input wire logic [1:0] ext_pin_shared,
	input wire logic [1:0] ext_pin_is_input,
	input wire logic time_base_zero_evt,
	input wire logic time_base_one_evt,
	input wire logic eeprom_done_evt,
	input wire logic conversion_done_evt,
	input wire logic low_voltage_evt,
	input wire logic std_match_a_evt,
	input wire logic std_match_p_evt,
	input wire logic per_match_a_evt,
	input wire logic per_match_p_evt,
	input wire logic serial_uart_mode,
	input wire sync_events_s serial_sync_evt,
	input wire uart_events_s serial_uart_evt,
	input wire core_status_s core,
	output logic stack_push,
	output logic [PC_W-1:0] push_pc,
	output logic stack_pop,
	output logic pc_load,
	output logic [PC_W-1:0] pc_vector,
	output logic [3:0] taken_src,
	output logic wake_up
);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic global_irq_enable;
	logic [1:0] ext_pin_enable;
	logic serial_module_enable;
	logic [1:0] ext_pin_flag;
	logic serial_module_flag;
	logic [3:0] grp1_flag;
	logic [3:0] grp1_en;
	logic [3:0] grp2_flag;
	logic [3:0] grp2_en;
	logic time_base_one_flag;
	logic time_base_one_enable;
	logic [3:0] ext_edge_select;
	logic [1:0] pin_q;
	take_e state;
	logic [3:0] sel_src;

	logic [NSRC-1:0] flags;
	logic [NSRC-1:0] enables;
	logic [NSRC-1:0] pending;
	logic [NSRC-1:0] flags_q;
	logic [NSRC-1:0] svc_clr;
	logic [1:0] ext_hit;
	logic serial_hit;
	logic take;
	logic [3:0] win;
	logic found;
	logic [3:0] grp1_evt;
	logic [3:0] grp2_evt;

	// Edge detector against the chosen type
	function automatic logic edge_hit(input logic [1:0] sel,
		input logic prev, input logic now);
		edge_hit = 1'b0;
		unique case (sel)
			EDGE_OFF: edge_hit = 1'b0;
			EDGE_RISE: edge_hit = !prev && now;
			EDGE_FALL: edge_hit = prev && !now;
			EDGE_BOTH: edge_hit = prev ^ now;
		endcase
	endfunction

	// Write hit on one register
	function automatic logic wr_hit(input logic [2:0] a);
		wr_hit = reg_wr && (reg_addr == a);
	endfunction

	// ------------------------------------------------------------
	// Event collection
	// ------------------------------------------------------------
	// Pin qualifies only with enable, pin-share and input direction
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			ext_hit[i] = ext_pin_enable[i] && ext_pin_shared[i]
				&& ext_pin_is_input[i]
				&& edge_hit(ext_edge_select[2*i +: 2], pin_q[i],
				i == 0 ? ext_pin_zero : ext_pin_one);
		end
	end

	// Serial flag source depends on the interface mode
	assign serial_hit = serial_uart_mode ? |serial_uart_evt
		: |serial_sync_evt;

	// Group events gathered in flag bit order, highest bit first
	assign grp1_evt = {time_base_zero_evt, eeprom_done_evt,
		conversion_done_evt, low_voltage_evt};
	assign grp2_evt = {std_match_a_evt, std_match_p_evt,
		per_match_a_evt, per_match_p_evt};

	// Input history for edge detection
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pin_q <= 2'h0;
		else
			pin_q <= {ext_pin_one, ext_pin_zero};
	end

	// ------------------------------------------------------------
	// Priority and acceptance
	// ------------------------------------------------------------
	assign flags = {2'h0, time_base_one_flag, grp2_flag[3], grp2_flag[2],
		grp2_flag[1], grp2_flag[0], grp1_flag[3], grp1_flag[2],
		grp1_flag[1], grp1_flag[0], serial_module_flag, ext_pin_flag};
	assign enables = {2'h0, time_base_one_enable, grp2_en[3], grp2_en[2],
		grp2_en[1], grp2_en[0], grp1_en[3], grp1_en[2],
		grp1_en[1], grp1_en[0], serial_module_enable, ext_pin_enable};
	assign pending = flags & enables;

	// Lowest index wins, giving a fixed order
	always_comb
	begin
		win = 4'h0;
		found = 1'b0;
		for (int i = NSRC - 1; i >= 0; i--)
		begin
			if (pending[i])
			begin
				win = 4'(i);
				found = 1'b1;
			end
		end
	end

	// Full stack holds off acknowledgement; request stays pending
	assign take = (state == ST_RUN) && found && global_irq_enable
		&& !core.stack_full && core.fetch_ok;

	// ------------------------------------------------------------
	// Take sequence: push, then load the vector
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= ST_RUN;
			sel_src <= 4'h0;
		end
		else
		begin
			unique case (state)
				ST_RUN:
					if (take)
					begin
						state <= ST_PUSH;
						sel_src <= win;
					end
				ST_PUSH: state <= ST_LOAD;
				ST_LOAD: state <= ST_RUN;
				// Unused code falls back to idle
				default: state <= ST_RUN;
			endcase
		end
	end

	// Core-facing outputs registered so the vector data is stable
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stack_push <= 1'b0;
			push_pc <= '0;
			pc_load <= 1'b0;
			pc_vector <= '0;
			taken_src <= 4'h0;
			stack_pop <= 1'b0;
		end
		else
		begin
			stack_push <= take;
			if (take)
				push_pc <= core.next_pc[PC_W-1:0];
			pc_load <= (state == ST_PUSH);
			if (state == ST_PUSH)
			begin
				pc_vector <= PC_W'(VEC_BASE + VEC_STEP * 12'(sel_src));
				taken_src <= sel_src;
			end
			stack_pop <= core.ret_irq;
		end
	end

	// Service clears exactly the taken source's flag
	always_comb
	begin
		svc_clr = '0;
		if (take)
			svc_clr[win] = 1'b1;
	end

	// ------------------------------------------------------------
	// Flags: hardware set beats any clear in the same cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ext_pin_flag <= 2'h0;
			serial_module_flag <= 1'b0;
			grp1_flag <= 4'h0;
			grp2_flag <= 4'h0;
			time_base_one_flag <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (ext_hit[i])
					ext_pin_flag[i] <= 1'b1;
				else if (svc_clr[SRC_EXT0 + i])
					ext_pin_flag[i] <= 1'b0;
				else if (wr_hit(ADDR_CTRL0))
					ext_pin_flag[i] <= reg_wdata[FLAG_LO + i];
			end
			if (serial_hit)
				serial_module_flag <= 1'b1;
			else if (svc_clr[SRC_SERIAL])
				serial_module_flag <= 1'b0;
			else if (wr_hit(ADDR_CTRL0))
				serial_module_flag <= reg_wdata[6];
			// Group 1 bit order: low voltage, conversion, eeprom, tb0
			for (int i = 0; i < GRP_W; i++)
			begin
				if (grp1_evt[i])
					grp1_flag[i] <= 1'b1;
				else if (svc_clr[SRC_LOWV + i])
					grp1_flag[i] <= 1'b0;
				else if (wr_hit(ADDR_CTRL1))
					grp1_flag[i] <= reg_wdata[FLAG_LO + i];
			end
			// Group 2 bit order: per P, per A, std P, std A
			for (int i = 0; i < GRP_W; i++)
			begin
				if (grp2_evt[i])
					grp2_flag[i] <= 1'b1;
				else if (svc_clr[SRC_PERP + i])
					grp2_flag[i] <= 1'b0;
				else if (wr_hit(ADDR_CTRL2))
					grp2_flag[i] <= reg_wdata[FLAG_LO + i];
			end
			if (time_base_one_evt)
				time_base_one_flag <= 1'b1;
			else if (svc_clr[SRC_TB1])
				time_base_one_flag <= 1'b0;
			else if (wr_hit(ADDR_CTRL3))
				time_base_one_flag <= reg_wdata[FLAG_LO];
		end
	end

	// ------------------------------------------------------------
	// Enables; taking an interrupt clears the global enable
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			global_irq_enable <= 1'b0;
			ext_pin_enable <= 2'h0;
			serial_module_enable <= 1'b0;
			grp1_en <= 4'h0;
			grp2_en <= 4'h0;
			time_base_one_enable <= 1'b0;
			ext_edge_select <= 4'h0;
		end
		else
		begin
			if (take)
				global_irq_enable <= 1'b0;
			else if (wr_hit(ADDR_CTRL0))
				global_irq_enable <= reg_wdata[GIE_BIT];
			if (wr_hit(ADDR_CTRL0))
			begin
				ext_pin_enable <= reg_wdata[2:1];
				serial_module_enable <= reg_wdata[3];
			end
			if (wr_hit(ADDR_CTRL1))
				grp1_en <= reg_wdata[EN_LO +: GRP_W];
			if (wr_hit(ADDR_CTRL2))
				grp2_en <= reg_wdata[EN_LO +: GRP_W];
			if (wr_hit(ADDR_CTRL3))
				time_base_one_enable <= reg_wdata[EN_LO];
			if (wr_hit(ADDR_EDGE))
				ext_edge_select <= reg_wdata[3:0];
		end
	end

	// ------------------------------------------------------------
	// Wake-up on any flag rising, independent of enables
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			flags_q <= '0;
			wake_up <= 1'b0;
		end
		else
		begin
			flags_q <= flags;
			// Only a 0->1 change wakes, so a preset flag suppresses it
			wake_up <= |(flags & ~flags_q);
		end
	end

	// ------------------------------------------------------------
	// Read port: data one cycle after the strobe, else zero
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= RESET_VAL;
		else if (!reg_rd)
			reg_rdata <= RESET_VAL;
		else
		begin
			unique case (reg_addr)
				ADDR_CTRL0: reg_rdata <= CTRL0_MASK & {1'b0,
					serial_module_flag, ext_pin_flag, serial_module_enable,
					ext_pin_enable, global_irq_enable};
				ADDR_CTRL1: reg_rdata <= {grp1_flag, grp1_en};
				ADDR_CTRL2: reg_rdata <= {grp2_flag, grp2_en};
				ADDR_CTRL3: reg_rdata <= CTRL3_MASK & {3'h0,
					time_base_one_flag, 3'h0, time_base_one_enable};
				ADDR_EDGE: reg_rdata <= EDGE_MASK & {4'h0, ext_edge_select};
				ADDR_STATUS: reg_rdata <= {2'h0, state, sel_src};
				default: reg_rdata <= RESET_VAL;
			endcase
		end
	end

endmodule

// ===== verification/core_model.sv
// Behavioural processor core: program counter and return stack
`timescale 1ns/100ps

module core_model
	import irq_pkg::*;
#(
	parameter int DEPTH = 2
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic ret_req,
	input wire logic stack_push,
	input wire logic [11:0] push_pc,
	input wire logic stack_pop,
	input wire logic pc_load,
	input wire logic [11:0] pc_vector,
	output core_status_s core
);
	logic [11:0] pc;
	logic [11:0] stk [DEPTH];
	int depth;
	// ------------------------------------------------------------
	// Stack and program counter
	// ------------------------------------------------------------
	// A push into a full stack is dropped, as real hardware would lose it
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pc <= 12'h100;
			depth <= 0;
		end
		else if (stack_push && depth < DEPTH)
		begin
			stk[depth] <= push_pc;
			depth <= depth + 1;
		end
		else if (stack_pop && depth > 0)
		begin
			pc <= stk[depth-1];
			depth <= depth - 1;
		end
		else if (pc_load)
			pc <= pc_vector;
	end
	// Core always reports fetch_ok; only a full stack holds off an interrupt
	assign core = '{next_pc: pc, stack_full: depth >= DEPTH,
		ret_irq: ret_req, fetch_ok: 1'b1};
endmodule

// ===== verification/irq_ctrl_props.sv
// Port level checker for the interrupt controller
`timescale 1ns/100ps

module irq_ctrl_props
	import irq_pkg::*;
#(
	parameter int PC_W = 12
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire core_status_s core,
	input wire logic stack_push,
	input wire logic [PC_W-1:0] push_pc,
	input wire logic stack_pop,
	input wire logic pc_load,
	input wire logic [PC_W-1:0] pc_vector,
	input wire logic [3:0] taken_src
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// ------------------------------------------------------------
	// Take and return sequence
	// ------------------------------------------------------------
	a_push_then_load: assert property (stack_push |=> pc_load)
		else $error("vector load did not follow push");
	a_load_needs_push: assert property (pc_load |-> $past(stack_push))
		else $error("vector load without push");
	a_push_pc_saved: assert property (stack_push |->
		push_pc == $past(core.next_pc))
		else $error("pushed address is not the next address");
	a_vector_per_src: assert property (pc_load |-> taken_src <= 4'hB &&
		pc_vector == PC_W'(VEC_BASE + VEC_STEP * taken_src))
		else $error("vector does not match source");
	// A full stack would lose the return address, so no push may follow
	a_full_blocks: assert property (stack_push |->
		!$past(core.stack_full))
		else $error("push while stack full");
	a_pop_on_return: assert property (core.ret_irq |=> stack_pop)
		else $error("no pop after return");
	// Global enable is cleared by the take, so a retake needs a rewrite
	a_no_quick_retake: assert property (stack_push |=> !stack_push [*2])
		else $error("take repeated too soon");
	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_unmapped_zero: assert property ($past(reg_rd) &&
		$past(reg_addr) > 3'h5 |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	c_take: cover property (pc_load);
	c_pop: cover property (stack_pop);
	c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind mcu_interrupt_controller irq_ctrl_props #(.PC_W(PC_W)) props_u (
	.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .core(core), .stack_push(stack_push),
	.push_pc(push_pc), .stack_pop(stack_pop), .pc_load(pc_load),
	.pc_vector(pc_vector), .taken_src(taken_src)
);

// ===== verification/testbench.sv
// Register level testbench of the interrupt controller
`timescale 1ns/100ps

module testbench
	import irq_pkg::*;
;
	logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, ret_req = 0;
	logic [2:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0, reg_rdata;
	logic pin0 = 0, umode = 0;
	logic [1:0] shr = 2'h3, inp = 2'h3;
	logic [8:0] ev = '0;
	sync_events_s ssync = '0;
	uart_events_s suart = '0;
	core_status_s core;
	logic stack_push, stack_pop, pc_load, wake_up;
	logic [11:0] push_pc, pc_vector;
	logic [3:0] taken_src;
	int miscompares = 0, n_tests = 0, pushes = 0, wakes = 0;

	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		pushes += (stack_push === 1'b1);
		wakes += (wake_up === 1'b1);
	end

	mcu_interrupt_controller dut_u (.clk(clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin_zero(pin0),
		.ext_pin_one(1'b0), .ext_pin_shared(shr), .ext_pin_is_input(inp),
		.time_base_zero_evt(ev[0]), .time_base_one_evt(ev[1]),
		.eeprom_done_evt(ev[2]), .conversion_done_evt(ev[3]),
		.low_voltage_evt(ev[4]), .std_match_a_evt(ev[5]),
		.std_match_p_evt(ev[6]), .per_match_a_evt(ev[7]),
		.per_match_p_evt(ev[8]), .serial_uart_mode(umode),
		.serial_sync_evt(ssync), .serial_uart_evt(suart), .core(core),
		.stack_push(stack_push), .push_pc(push_pc), .stack_pop(stack_pop),
		.pc_load(pc_load), .pc_vector(pc_vector), .taken_src(taken_src),
		.wake_up(wake_up));
	core_model core_u (.clk(clk), .rstn(rstn), .ret_req(ret_req),
		.stack_push(stack_push), .push_pc(push_pc), .stack_pop(stack_pop),
		.pc_load(pc_load), .pc_vector(pc_vector), .core(core));

	// ------------------------------------------------------------
	// Access and checking tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [11:0] seen,
		input logic [11:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", {4'h0, reg_rdata}, {4'h0, e});
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev <= '0;
	endtask
	task automatic ret_pulse();
		@(posedge clk);
		ret_req <= 1'b1;
		@(posedge clk);
		ret_req <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic no_take(input int n);
		int p;
		p = pushes;
		repeat (n) @(posedge clk);
		check("push count", 12'(pushes), 12'(p));
	endtask
	// Bounded wait for the vector load, then optional return
	task automatic take(input int src, input bit do_ret);
		logic [11:0] saved;
		int n;
		saved = core.next_pc;
		n = 0;
		while (pc_load !== 1'b1 && n < 30)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 30)
		begin
			miscompares++;
			complete_run();
		end
		check("taken_src", {8'h0, taken_src}, 12'(src));
		check("pc_vector", pc_vector, 12'(VEC_BASE + VEC_STEP * src));
		if (do_ret)
		begin
			ret_pulse();
			check("next_pc", core.next_pc, saved);
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < 8; a++)
			rd(3'(a), 8'h00);
		wr(ADDR_CTRL1, 8'hFF);
		rd(ADDR_CTRL1, 8'hFF);
		wr(ADDR_CTRL2, 8'hFF);
		rd(ADDR_CTRL2, 8'hFF);
		wr(ADDR_CTRL3, 8'hFF);
		rd(ADDR_CTRL3, 8'h11);
		wr(ADDR_CTRL0, 8'hFE);
		rd(ADDR_CTRL0, 8'h7E);
		for (int a = 0; a < 5; a++)
			wr(3'(a), 8'h00);
		// Flag without its enable sets but never jumps
		wr(ADDR_CTRL0, 8'h01);
		pulse(3);
		no_take(6);
		rd(ADDR_CTRL1, 8'h20);
		wr(ADDR_CTRL1, 8'h22);
		take(SRC_CONV, 1);
		rd(ADDR_CTRL0, 8'h00);
		rd(ADDR_CTRL1, 8'h02);
		// Global enable low holds the request back
		wr(ADDR_CTRL1, 8'h08);
		pulse(0);
		no_take(6);
		rd(ADDR_CTRL1, 8'h88);
		wr(ADDR_CTRL0, 8'h01);
		take(SRC_TB0, 1);
		// All four timer requests pending at once
		wr(ADDR_CTRL2, 8'hFF);
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CTRL0, 8'h01);
			take(SRC_PERP + i, 1);
		end
		// Edge codes on external pin zero
		for (int c = 0; c < 4; c++)
		begin
			wr(ADDR_EDGE, 8'(c));
			wr(ADDR_CTRL0, 8'h02);
			pin0 <= 1'b1;
			rd(ADDR_CTRL0, c[0] ? 8'h12 : 8'h02);
			wr(ADDR_CTRL0, 8'h02);
			pin0 <= 1'b0;
			rd(ADDR_CTRL0, c[1] ? 8'h12 : 8'h02);
		end
		wr(ADDR_CTRL0, 8'h02);
		inp <= 2'h2;
		pin0 <= 1'b1;
		rd(ADDR_CTRL0, 8'h02);
		inp <= 2'h3;
		wr(ADDR_CTRL0, 8'h13);
		take(SRC_EXT0, 1);
		rd(ADDR_CTRL0, 8'h02);
		// Every serial condition in both mode groups
		for (int b = 0; b < 9; b++)
		begin
			wr(ADDR_CTRL0, 8'h00);
			umode <= (b > 2);
			ssync <= (b < 3) ? 3'(1 << b) : 3'h0;
			suart <= (b > 2) ? 6'(1 << (b - 3)) : 6'h00;
			@(posedge clk);
			ssync <= '0;
			suart <= '0;
			rd(ADDR_CTRL0, 8'h40);
		end
		wr(ADDR_CTRL0, 8'h49);
		take(SRC_SERIAL, 1);
		rd(ADDR_CTRL0, 8'h08);
		// Wake only on a rising flag
		begin
			int w;
			w = wakes;
			wr(ADDR_CTRL1, 8'h00);
			pulse(4);
			no_take(3);
			check("wake count", 12'(wakes), 12'(w + 1));
			w = wakes;
			pulse(4);
			repeat (3) @(posedge clk);
			check("wake count", 12'(wakes), 12'(w));
			wr(ADDR_CTRL1, 8'h00);
			pulse(4);
			repeat (3) @(posedge clk);
			check("wake count", 12'(wakes), 12'(w + 1));
		end
		// Nesting until the stack is full, then unwind
		wr(ADDR_CTRL1, 8'h11);
		wr(ADDR_CTRL3, 8'h11);
		wr(ADDR_CTRL0, 8'h01);
		take(SRC_LOWV, 0);
		wr(ADDR_CTRL0, 8'h01);
		take(SRC_TB1, 0);
		wr(ADDR_CTRL1, 8'h11);
		wr(ADDR_CTRL0, 8'h01);
		no_take(8);
		ret_pulse();
		take(SRC_LOWV, 1);
		ret_pulse();
		check("next_pc", core.next_pc, 12'h100);
		complete_run();
	end
endmodule
